// ===== serial_irq_agent_tb.sv
// Testbench joining the serial interrupt agent and host across the shared line
`timescale 1ns/100ps
`default_nettype none
module serial_irq_agent_tb
    import sirq_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic cycle_req = 1'b0;
    logic [2:0] start_extra = 3'h3;
    logic [5:0] frame_total = 6'h00;
    logic stop_quiet = 1'b0;
    logic [5:0] src = 6'h00;
    logic [31:0] irq_vec;
    logic vec_valid;
    logic busy;
    logic h_quiet;
    logic d_quiet;
    logic req_pending;
    logic [4:0] fr [6] = '{SIRQ_FR_KBD, SIRQ_FR_UARTB, SIRQ_FR_UARTA, SIRQ_FR_FDC,
        SIRQ_FR_LPT, SIRQ_FR_MOUSE};
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int off = 0;
    int reqs = 0;
    int last_off = 0;
    int r0;
    always #4 clock = ~clock;
    sirq_if sirq_if_i ();
    sirq_agent sirq_agent_i (.clock(clock), .sys_rst(sys_rst), .ce(ce), .bus(sirq_if_i),
        .kbd_irq(src[0]), .uartb_irq(src[1]), .uarta_irq(src[2]), .fdc_irq(src[3]),
        .lpt_irq(src[4]), .mouse_irq(src[5]), .quiet_mode(d_quiet),
        .req_pending(req_pending));
    sirq_host sirq_host_i (.clock(clock), .sys_rst(sys_rst), .ce(ce), .bus(sirq_if_i),
        .cycle_req(cycle_req), .start_extra(start_extra), .frame_total(frame_total),
        .stop_quiet(stop_quiet), .irq_vec(irq_vec), .vec_valid(vec_valid), .busy(busy),
        .quiet_mode(h_quiet));
    sirq_props sirq_props_i (.clock(clock), .sys_rst(sys_rst), .dev_out(sirq_if_i.dev_out),
        .dev_oe(sirq_if_i.dev_oe), .host_out(sirq_if_i.host_out),
        .host_oe(sirq_if_i.host_oe), .line(sirq_if_i.line));
    // ------------------------------------------------------------
    // Line watch and run limit
    // ------------------------------------------------------------
    // Offset counts clocks since the host's high clock; requests seen while idle
    always @(posedge clock) begin
        cyc <= cyc + 1;
        off <= (sirq_if_i.host_oe && sirq_if_i.host_out) ? 1 : off + 1;
        if (sirq_if_i.dev_oe === 1'b1 && sirq_if_i.dev_out === 1'b0) begin
            if (busy === 1'b1) begin
                last_off <= off;
            end else begin
                reqs <= reqs + 1;
            end
        end
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One whole cycle; a bounded wait so a silent host cannot hang the run
    task automatic run(input logic [2:0] ex, input logic [5:0] ft, input logic sq,
        input logic rq, input logic [5:0] s);
        int n;
        @(posedge clock);
        start_extra <= ex;
        frame_total <= ft;
        stop_quiet <= sq;
        cycle_req <= rq;
        src <= s;
        ce <= 1'b1;
        @(posedge clock);
        cycle_req <= 1'b0;
        #1;
        n = 0;
        while (vec_valid !== 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 400) begin
            err_count++;
        end
    endtask : run
    task automatic summarize();
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        chk(d_quiet, 32'h0);
        chk(h_quiet, 32'h0);
        @(posedge clock);
        src <= 6'h01;
        repeat (20) @(posedge clock);
        #1;
        chk(reqs, 32'h0);
        chk(busy, 32'h0);
        // Each source alone, with every start length and two frame counts
        for (int i = 0; i < 6; i++) begin
            run(3'(3 + i % 5), (i % 2) ? 6'h0d : 6'h00, 1'b0, 1'b1, 6'(1 << i));
            chk(irq_vec, 32'h1 << fr[i]);
            chk(last_off, 32'(2 + 3 * fr[i]));
        end
        run(3'h7, 6'h00, 1'b1, 1'b1, 6'h3f);
        chk(irq_vec, 32'h000010da);
        repeat (3) @(posedge clock);
        #1;
        chk(h_quiet, 32'h1);
        chk(d_quiet, 32'h1);
        run(3'h5, 6'h20, 1'b1, 1'b1, 6'h00);
        chk(irq_vec, 32'h0);
        r0 = reqs;
        // Frozen by the clock enable, a new source edge must not raise a request yet
        @(posedge clock);
        ce <= 1'b0;
        src <= 6'h20;
        repeat (8) @(posedge clock);
        #1;
        chk(reqs - r0, 32'h0);
        chk(req_pending, 32'h0);
        run(3'h3, 6'h00, 1'b0, 1'b0, 6'h20);
        chk(irq_vec, 32'h00001000);
        chk(reqs - r0, 32'h1);
        repeat (3) @(posedge clock);
        #1;
        chk(d_quiet, 32'h0);
        chk(req_pending, 32'h0);
        summarize();
    end
endmodule : serial_irq_agent_tb
`default_nettype wire

// ===== sirq_agent.sv
// Serial interrupt agent: reports six local sources on the shared line
`timescale 1ns/100ps
`default_nettype none
module sirq_agent
    import sirq_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    sirq_if.dev bus,
    input wire logic kbd_irq,
    input wire logic uartb_irq,
    input wire logic uarta_irq,
    input wire logic fdc_irq,
    input wire logic lpt_irq,
    input wire logic mouse_irq,
    output logic quiet_mode,
    output logic req_pending
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_FRAMES = 2'b01,
        D_TAIL = 2'b10
    } sirq_dst_t;

    sirq_dst_t state_reg;
    sirq_dst_t state_next;
    logic [4:0] frame_reg;
    logic [4:0] frame_next;
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic quiet_reg;
    logic quiet_next;
    logic pend_reg;
    logic pend_next;
    logic took_reg;
    logic took_next;
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;
    logic [5:0] src_prev_reg;
    logic [5:0] src_now;
    logic [5:0] src_rise;
    logic line_q;
    logic rise;
    logic [3:0] low_len;
    logic start_ok;
    logic stop_q;
    logic stop_c;
    logic req_ok;

    // ------------------------------------------------------------
    // Source to frame mapping
    // ------------------------------------------------------------
    function automatic logic sirq_src_sel(input logic [4:0] f, input logic [5:0] s);
        case (f)
            SIRQ_FR_KBD: return s[0];
            SIRQ_FR_UARTB: return s[1];
            SIRQ_FR_UARTA: return s[2];
            SIRQ_FR_FDC: return s[3];
            SIRQ_FR_LPT: return s[4];
            SIRQ_FR_MOUSE: return s[5];
            default: return 1'b0;
        endcase
    endfunction : sirq_src_sel

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    // line is registered on the PCI clock
    sirq_line_mon u_mon (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .line_i(bus.line),
        .line_q(line_q),
        .rise(rise),
        .low_len(low_len)
    );

    // Sources come from local logic on the same clock
    assign src_now = {mouse_irq, lpt_irq, fdc_irq, uarta_irq, uartb_irq, kbd_irq};
    assign src_rise = src_now & ~src_prev_reg;

    // a 4..8 clock low run is a start from anyone
    assign start_ok = rise && (low_len >= SIRQ_START_MIN) && (low_len <= SIRQ_START_MAX);
    assign stop_q = rise && (low_len == SIRQ_STOP_QUIET);
    assign stop_c = rise && (low_len == SIRQ_STOP_CONT);

    // request only between cycles with a fresh edge
    assign req_ok = (state_reg == D_IDLE) && quiet_reg && pend_reg && line_q && !oe_reg;

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        frame_next = frame_reg;
        phase_next = phase_reg;
        quiet_next = quiet_reg;
        // New edges set the pending flag; setting beats clearing
        pend_next = pend_reg | (|src_rise);
        case (state_reg)
            D_IDLE, D_TAIL: begin
                if (start_ok) begin
                    state_next = D_FRAMES;
                    frame_next = 5'h00;
                    phase_next = SIRQ_PH_SAMPLE;
                    pend_next = |src_rise;
                end else if (stop_q) begin
                    quiet_next = 1'b1;
                    state_next = D_IDLE;
                end else if (stop_c) begin
                    quiet_next = 1'b0;
                    state_next = D_IDLE;
                end
            end
            D_FRAMES: begin
                if (phase_reg == SIRQ_PH_TURN) begin
                    phase_next = SIRQ_PH_SAMPLE;
                    // after own frames wait for the stop
                    if (frame_reg == SIRQ_FR_DEV_LAST) begin
                        state_next = D_TAIL;
                    end else begin
                        frame_next = frame_reg + 5'h01;
                    end
                end else begin
                    phase_next = phase_reg + 2'h1;
                end
            end
            default: begin
                state_next = D_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Pin drive, decided one clock ahead so each phase starts on an edge
    // ------------------------------------------------------------
    always_comb begin
        out_next = 1'b1;
        oe_next = 1'b0;
        took_next = took_reg;
        if (state_next == D_FRAMES) begin
            case (phase_next)
                SIRQ_PH_SAMPLE: begin
                    // pull low for an active source
                    took_next = sirq_src_sel(frame_next, src_now);
                    out_next = 1'b0;
                    oe_next = took_next;
                end
                SIRQ_PH_RECOVER: begin
                    // drive high after our own low
                    out_next = 1'b1;
                    oe_next = took_reg;
                end
                default: begin
                    oe_next = 1'b0;
                end
            endcase
        end else if (req_ok && !start_ok) begin
            out_next = 1'b0;
            oe_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= D_IDLE;
            frame_reg <= 5'h00;
            phase_reg <= SIRQ_PH_SAMPLE;
            quiet_reg <= SIRQ_QUIET_RST;
            pend_reg <= 1'b0;
            took_reg <= 1'b0;
            out_reg <= 1'b1;
            oe_reg <= 1'b0;
            src_prev_reg <= 6'h00;
        end else if (ce) begin
            state_reg <= state_next;
            frame_reg <= frame_next;
            phase_reg <= phase_next;
            quiet_reg <= quiet_next;
            pend_reg <= pend_next;
            took_reg <= took_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            src_prev_reg <= src_now;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // enable only in the owned clocks, else released
    assign bus.dev_out = out_reg;
    assign bus.dev_oe = oe_reg;
    // mode and pending flags are level based, idle time is free
    assign quiet_mode = quiet_reg;
    assign req_pending = pend_reg;
endmodule : sirq_agent
`default_nettype wire

// ===== sirq_host.sv
// Host end of the serial interrupt line: starts, samples and stops cycles
`timescale 1ns/100ps
`default_nettype none
module sirq_host
    import sirq_pkg::*;
#(
    parameter int FRAMES_MAX = SIRQ_FRAMES_MAX
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    sirq_if.host bus,
    input wire logic cycle_req,
    input wire logic [2:0] start_extra,
    input wire logic [5:0] frame_total,
    input wire logic stop_quiet,
    output logic [FRAMES_MAX-1:0] irq_vec,
    output logic vec_valid,
    output logic busy,
    output logic quiet_mode
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (FRAMES_MAX > SIRQ_FRAMES_MAX || FRAMES_MAX <= int'(SIRQ_FR_DEV_LAST)) begin : g_chk
        $error("sirq_host: FRAMES_MAX out of range");
    end

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_LEAD = 3'b010,
        H_FRAMES = 3'b011,
        H_STOP = 3'b100,
        H_REC = 3'b101,
        H_TURN = 3'b110
    } sirq_hst_t;

    sirq_hst_t st_reg;
    sirq_hst_t st_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [3:0] len_reg;
    logic [3:0] len_next;
    logic [4:0] frame_reg;
    logic [4:0] frame_next;
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic [FRAMES_MAX-1:0] vec_reg;
    logic [FRAMES_MAX-1:0] vec_next;
    logic valid_reg;
    logic valid_next;
    logic busy_reg;
    logic quiet_reg;
    logic quiet_next;
    logic stopq_reg;
    logic stopq_next;
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;
    logic line_q;
    logic [3:0] extra_c;
    logic [5:0] ftot_c;

    sirq_line_mon u_mon (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .line_i(bus.line),
        .line_q(line_q),
        .rise(),
        .low_len()
    );

    // Low start extensions clamp to the minimum; a zero or too large frame total selects FRAMES_MAX
    assign extra_c = (start_extra < SIRQ_EXTRA_MIN) ? {1'b0, SIRQ_EXTRA_MIN} : {1'b0, start_extra};
    assign ftot_c = (frame_total == 6'h00 || frame_total > 6'(FRAMES_MAX)) ?
                    6'(FRAMES_MAX) : frame_total;

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        len_next = len_reg;
        frame_next = frame_reg;
        phase_next = phase_reg;
        vec_next = vec_reg;
        valid_next = 1'b0;
        quiet_next = quiet_reg;
        stopq_next = stopq_reg;
        out_next = 1'b1;
        oe_next = 1'b0;
        case (st_reg)
            H_IDLE: begin
                // Raw line: takeover must land on the very next clock
                if (quiet_reg && !bus.line && !oe_reg) begin
                    // extend the agent's one clock by 3..7
                    st_next = H_START;
                    len_next = extra_c;
                    cnt_next = 4'h1;
                    out_next = 1'b0;
                    oe_next = 1'b1;
                end else if (cycle_req) begin
                    st_next = H_START;
                    len_next = extra_c + 4'h1;
                    cnt_next = 4'h1;
                    out_next = 1'b0;
                    oe_next = 1'b1;
                end
            end
            H_START: begin
                oe_next = 1'b1;
                if (cnt_reg == len_reg) begin
                    // one clock high ends the start pulse
                    st_next = H_LEAD;
                    cnt_next = 4'h0;
                end else begin
                    cnt_next = cnt_reg + 4'h1;
                    out_next = 1'b0;
                end
            end
            H_LEAD: begin
                // first sample two clocks after the edge
                if (cnt_reg == SIRQ_FIRST_SAMPLE - 4'h1) begin
                    st_next = H_FRAMES;
                    frame_next = 5'h00;
                    phase_next = SIRQ_PH_SAMPLE;
                end else begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            H_FRAMES: begin
                // Registered line now shows the sample clock
                if (phase_reg == SIRQ_PH_RECOVER) begin
                    vec_next[frame_reg] = ~line_q;
                end
                if (phase_reg == SIRQ_PH_TURN) begin
                    phase_next = SIRQ_PH_SAMPLE;
                    if ({1'b0, frame_reg} == ftot_c - 6'h01) begin
                        // stop of 2 or 3 clocks low
                        st_next = H_STOP;
                        cnt_next = 4'h1;
                        len_next = stop_quiet ? SIRQ_STOP_QUIET : SIRQ_STOP_CONT;
                        stopq_next = stop_quiet;
                        out_next = 1'b0;
                        oe_next = 1'b1;
                    end else begin
                        frame_next = frame_reg + 5'h01;
                    end
                end else begin
                    phase_next = phase_reg + 2'h1;
                end
            end
            H_STOP: begin
                oe_next = 1'b1;
                if (cnt_reg == len_reg) begin
                    st_next = H_REC;
                end else begin
                    cnt_next = cnt_reg + 4'h1;
                    out_next = 1'b0;
                end
            end
            H_REC: begin
                st_next = H_TURN;
            end
            H_TURN: begin
                // cycle complete; mode for the next one
                st_next = H_IDLE;
                valid_next = 1'b1;
                quiet_next = stopq_reg;
            end
            default: begin
                st_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg <= H_IDLE;
            cnt_reg <= 4'h0;
            len_reg <= 4'h0;
            frame_reg <= 5'h00;
            phase_reg <= SIRQ_PH_SAMPLE;
            vec_reg <= '0;
            valid_reg <= 1'b0;
            busy_reg <= 1'b0;
            quiet_reg <= SIRQ_QUIET_RST;
            stopq_reg <= SIRQ_QUIET_RST;
            out_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            len_reg <= len_next;
            frame_reg <= frame_next;
            phase_reg <= phase_next;
            vec_reg <= vec_next;
            valid_reg <= valid_next;
            busy_reg <= (st_next != H_IDLE);
            quiet_reg <= quiet_next;
            stopq_reg <= stopq_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    // host drives only start, high, stop and recovery clocks
    assign bus.host_out = out_reg;
    assign bus.host_oe = oe_reg;
    assign irq_vec = vec_reg;
    assign vec_valid = valid_reg;
    assign busy = busy_reg;
    assign quiet_mode = quiet_reg;
endmodule : sirq_host
`default_nettype wire

// ===== sirq_if.sv
// Shared open-drain serial interrupt line between agent and host
`timescale 1ns/100ps
`default_nettype none
interface sirq_if;
    logic dev_out;
    logic dev_oe;
    logic host_out;
    logic host_oe;
    logic line;

    // Wired level: any enabled low wins, pull-up otherwise
    assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

    modport dev (input line, output dev_out, output dev_oe);
    modport host (input line, output host_out, output host_oe);
endinterface : sirq_if
`default_nettype wire

// ===== sirq_line_mon.sv
// Line input register with low-run length measurement
`timescale 1ns/100ps
`default_nettype none
module sirq_line_mon
    import sirq_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic line_i,
    output logic line_q,
    output logic rise,
    output logic [3:0] low_len
);
    logic line_reg;
    logic line_next;
    logic [3:0] low_reg;
    logic [3:0] low_next;

    // Low run counter, saturating so long lows never wrap
    always_comb begin
        line_next = line_i;
        low_next = low_reg;
        if (line_reg) begin
            low_next = 4'h0;
        end else if (low_reg != SIRQ_LOWCNT_MAX) begin
            low_next = low_reg + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            line_reg <= 1'b1;
            low_reg <= 4'h0;
        end else if (ce) begin
            line_reg <= line_next;
            low_reg <= low_next;
        end
    end

    // Count still holds the finished run on the rising cycle
    assign line_q = line_reg;
    assign rise = line_reg & (low_reg != 4'h0);
    assign low_len = low_reg;
endmodule : sirq_line_mon
`default_nettype wire

// ===== sirq_pkg.sv
// Constants shared by the serial interrupt agent, its host end and the line monitor
// Summary of operation
// - Shared open-drain line; drive only defined clocks
// - All frame timing counted in PCI clocks
// - Cycle is start, data frames, then stop
// - Quiet mode: agent pulls low one clock
// - Host extends start low 3 to 7 clocks
// - Host drives high one clock, then floats
// - Continuous mode: only host starts, 4-8 low
// - After reset agent assumes Continuous mode
// - Count frames from start pulse rising edge
// - Frame is sample, recovery, turn-around clocks
// - Sample phase: pull low if source active
// - Recovery phase: drive high one clock
// - Turn-around phase: line left floating
// - Drive from IRQ0 frame, edge aligned
// - Fixed frame order, IRQ0 two clocks after
// - Fixed source frames: 1,3,4,6,7,12
// - Host ends cycle with 2-3 clock stop
// - Stop length selects next cycle's mode
// - Tolerate idle clocks; late or immediate start
package sirq_pkg;
    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int SIRQ_FRAMES_MAX = 32;
    localparam logic [3:0] SIRQ_START_MIN = 4'h4;
    localparam logic [3:0] SIRQ_START_MAX = 4'h8;
    localparam logic [2:0] SIRQ_EXTRA_MIN = 3'h3;
    localparam logic [3:0] SIRQ_STOP_QUIET = 4'h2;
    localparam logic [3:0] SIRQ_STOP_CONT = 4'h3;
    localparam logic [3:0] SIRQ_FIRST_SAMPLE = 4'h2;
    localparam logic [3:0] SIRQ_LOWCNT_MAX = 4'hf;
    // Phase codes inside one data frame
    localparam logic [1:0] SIRQ_PH_SAMPLE = 2'h0;
    localparam logic [1:0] SIRQ_PH_RECOVER = 2'h1;
    localparam logic [1:0] SIRQ_PH_TURN = 2'h2;
    // ------------------------------------------------------------
    // Frame slots used by the agent's sources
    // ------------------------------------------------------------
    localparam logic [4:0] SIRQ_FR_KBD = 5'h01;
    localparam logic [4:0] SIRQ_FR_UARTB = 5'h03;
    localparam logic [4:0] SIRQ_FR_UARTA = 5'h04;
    localparam logic [4:0] SIRQ_FR_FDC = 5'h06;
    localparam logic [4:0] SIRQ_FR_LPT = 5'h07;
    localparam logic [4:0] SIRQ_FR_MOUSE = 5'h0c;
    localparam logic [4:0] SIRQ_FR_DEV_LAST = 5'h0c;
    // Reset value of the mode flag: continuous
    localparam logic SIRQ_QUIET_RST = 1'b0;
endpackage : sirq_pkg

// ===== sirq_props.sv
// Checker of the shared serial interrupt line between agent and host
`timescale 1ns/100ps
`default_nettype none
module sirq_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic host_out,
    input wire logic host_oe,
    input wire logic line
);
    // ------------------------------------------------------------
    // Host low-run counter
    // ------------------------------------------------------------
    logic [3:0] hlow_reg;
    logic [3:0] hlow_next;
    logic dev_low;
    logic host_low;
    logic host_high;
    // Drive qualifiers of each party
    assign dev_low = dev_oe & ~dev_out;
    assign host_low = host_oe & ~host_out;
    assign host_high = host_oe & host_out;
    // Saturates so a stuck host cannot wrap back under the limit
    always_comb begin
        hlow_next = 4'h0;
        if (host_low) begin
            hlow_next = (hlow_reg == 4'hf) ? hlow_reg : hlow_reg + 4'h1;
        end
    end
    always_ff @(posedge clock) begin
        hlow_reg <= sys_rst ? 4'h0 : hlow_next;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Line properties
    // ------------------------------------------------------------
    property p_no_clash;
        !(dev_oe && host_oe);
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive the line");
    property p_dev_low_one;
        dev_low |=> !dev_low;
    endproperty
    a_dev_low_one: assert property (p_dev_low_one) else $error("agent low too long");
    property p_dev_low_next;
        dev_low |=> (host_low || (dev_oe && dev_out));
    endproperty
    a_dev_low_next: assert property (p_dev_low_next) else $error("no recovery after low");
    property p_dev_rec_turn;
        dev_oe && dev_out |=> !dev_oe;
    endproperty
    a_dev_rec_turn: assert property (p_dev_rec_turn) else $error("agent drives in turn");
    property p_host_hi_float;
        host_high |=> !host_oe && !dev_oe;
    endproperty
    a_host_hi_float: assert property (p_host_hi_float) else $error("line not floated");
    property p_host_low_max;
        hlow_reg <= 4'h8;
    endproperty
    a_host_low_max: assert property (p_host_low_max) else $error("host low run too long");
    property p_host_low_min;
        host_high |-> hlow_reg >= 4'h2;
    endproperty
    a_host_low_min: assert property (p_host_low_min) else $error("host low run too short");
    property p_start_len;
        dev_low ##1 host_low |=> host_low [*2];
    endproperty
    a_start_len: assert property (p_start_len) else $error("start extension short");
    property p_rst_cont;
        $fell(sys_rst) |-> !dev_oe [*8];
    endproperty
    a_rst_cont: assert property (p_rst_cont) else $error("agent drives after reset");
    // Main scenarios reached
    c_quiet_req: cover property (dev_low ##1 host_low);
    c_recover: cover property (dev_oe && dev_out);
    c_stop_two: cover property ($rose(line) && hlow_reg == 4'h2);
    c_stop_three: cover property ($rose(line) && hlow_reg == 4'h3);
endmodule : sirq_props
`default_nettype wire
